// File: hw/fdsp_pkg.sv
// Constants for the flash deep sleep power controller.
// Assumes a 10 MHz core clock; all intervals are derived from it.
package fdsp_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 100;
  localparam int POWER_UP_DELAY_NS   = 300000;
  localparam int SLEEP_ENTRY_TIME_NS = 3000;
  localparam int WAKE_PULSE_WIDTH_NS = 200;
  localparam int WAKE_EXIT_TIME_NS   = 200000;
  // Least times round up, and no count falls below one cycle
  localparam int POWER_UP_CYC   = (POWER_UP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS) < 1 ? 1
                                   : (SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS);
  localparam int WAKE_PULSE_CYC = (WAKE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_EXIT_CYC  = (WAKE_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W          = 12;

  // ----------------------------------------------------------------
  // Link command and register layout
  // ----------------------------------------------------------------
  localparam logic [7:0] ENTER_DEEP_SLEEP_CMD = 8'hB9;
  localparam int         READY_BUSY_BIT       = 0;
  localparam int         SLEEP_AFTER_PON_BIT  = 2;
  localparam logic [7:0] STATUS_ONE_RESET     = 8'h00;
  localparam logic [7:0] CONFIG_FOUR_V_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_POR   = 5'h01,
    ST_ENTRY = 5'h02,
    ST_SLEEP = 5'h04,
    ST_EXIT  = 5'h08,
    ST_ACT   = 5'h10
  } fdsp_state_type;

endpackage

// File: hw/fdsp_power_ctrl.sv
// Deep sleep entry, exit and power-up sequencing for a serial flash.
// Assumes the host drives chip select, serial clock and data; the serial
// clock stands still while chip select is high.
//
// Summary of operation
// - Chip select low selects, high deselects.
// - Extra clocks after opcode cancel sleep command.
// - Reach deep sleep within entry interval.
// - Sleep command accepted only when not busy.
// - Sleep bit set: power-on and hardware resets end in sleep, except a reset after power-on sleep.
// - Hardware reset in sleep returns to standby when sleep bit clear.
// - Long chip select low pulse wakes device.
// - After wake, fresh falling edge starts transaction.
// - Ignore interface during wake exit interval.
// - Configuration survives deep sleep unchanged.
// - Sleep passage clears diagnostic registers.
// - Ignore transactions until power-up delay ends.
// - Power-up done clears write enable latch.
// - Reset wakes device that powered up asleep.
// - Reset restarts incomplete power-on sequence.
// - Resets copy non-volatile into volatile bits.
// - Non-volatile writes also update volatile bits.
// - Volatile writes leave non-volatile bits unchanged.
`timescale 1ns/1ps
module fdsp_power_ctrl #(
  parameter int POWER_UP_CYCLES   = fdsp_pkg::POWER_UP_CYC,
  parameter int SLEEP_ENTRY_CYCLES = fdsp_pkg::SLEEP_ENTRY_CYC,
  parameter int WAKE_PULSE_CYCLES = fdsp_pkg::WAKE_PULSE_CYC,
  parameter int WAKE_EXIT_CYCLES  = fdsp_pkg::WAKE_EXIT_CYC
) (
  input  wire logic       mclk_in,
  input  wire logic       srst_in,
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic       si_in,
  input  wire logic       hw_reset_n_in,
  input  wire logic       supply_ok_in,
  input  wire logic       busy_in,
  input  wire logic       sw_reset_in,
  input  wire logic       wel_set_in,
  input  wire logic [7:0] nv_image_in,
  input  wire logic       nv_wr_in,
  input  wire logic       v_wr_in,
  input  wire logic [7:0] wr_data_in,
  output logic            deep_sleep_out,
  output logic            device_ready_out,
  output logic            write_enable_latch_out,
  output logic [7:0]      status_one_volatile_out,
  output logic [7:0]      config_four_volatile_out,
  output logic [7:0]      config_four_nv_copy_out,
  output logic            diag_clear_out
);

  // ----------------------------------------------------------------
  // Link side: opcode shifter on the serial clock
  // ----------------------------------------------------------------
  // Cleared by chip select high, so every frame starts from bit zero.
  logic [3:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic       op_ok_r;
  logic       extra_r;
  wire        byte_done = (bit_cnt_r == 4'h7);
  wire        is_enter  = ({shift_r, si_in} == fdsp_pkg::ENTER_DEEP_SLEEP_CMD);

  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_cnt_r <= 4'h0;
      shift_r   <= 7'h00;
      op_ok_r   <= 1'b0;
      extra_r   <= 1'b0;
    end else begin
      if (bit_cnt_r != 4'h8) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      shift_r <= {shift_r[5:0], si_in};
      if (byte_done) begin
        op_ok_r <= is_enter;
      end
      if (bit_cnt_r == 4'h8) begin
        extra_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers into the core clock
  // ----------------------------------------------------------------
  logic [1:0] cs_s_r;
  logic [1:0] rst_s_r;
  logic [1:0] pwr_s_r;
  logic [1:0] op_s_r;
  logic [1:0] ex_s_r;
  logic       cs_d_r;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cs_s_r  <= 2'b11;
      rst_s_r <= 2'b11;
      pwr_s_r <= 2'b00;
      op_s_r  <= 2'b00;
      ex_s_r  <= 2'b00;
      cs_d_r  <= 1'b1;
    end else begin
      cs_s_r  <= {cs_s_r[0], cs_n_in};
      rst_s_r <= {rst_s_r[0], hw_reset_n_in};
      pwr_s_r <= {pwr_s_r[0], supply_ok_in};
      op_s_r  <= {op_s_r[0], op_ok_r};
      ex_s_r  <= {ex_s_r[0], extra_r};
      cs_d_r  <= cs_s_r[1];
    end
  end

  wire cs_n_s   = cs_s_r[1];
  wire hw_rst   = ~rst_s_r[1];
  wire pwr_ok   = pwr_s_r[1];
  wire cs_fall  = cs_d_r & ~cs_n_s;
  wire cs_rise  = ~cs_d_r & cs_n_s;

  // ----------------------------------------------------------------
  // Frame tracking in the core domain
  // ----------------------------------------------------------------
  fdsp_pkg::fdsp_state_type state_r;
  fdsp_pkg::fdsp_state_type state_nxt;
  logic                     frame_ok_r;
  logic                     cmd_arm_r;
  logic                     cmd_kill_r;

  wire active    = (state_r == fdsp_pkg::ST_ACT);
  // Only frames opened by a falling edge while active count
  wire frame_nxt = cs_fall ? active : (cs_n_s ? 1'b0 : frame_ok_r);

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      frame_ok_r <= 1'b0;
      cmd_arm_r  <= 1'b0;
      cmd_kill_r <= 1'b0;
    end else begin
      frame_ok_r <= frame_nxt;
      if (cs_fall) begin
        cmd_arm_r  <= 1'b0;
        cmd_kill_r <= 1'b0;
      end else if (frame_ok_r && !cs_n_s) begin
        cmd_arm_r  <= cmd_arm_r | op_s_r[1];
        cmd_kill_r <= cmd_kill_r | ex_s_r[1];
      end
    end
  end

  // Busy blocks the command; raised chip select right after the opcode runs it
  wire enter_cmd = cs_rise & frame_ok_r & cmd_arm_r & ~cmd_kill_r & ~busy_in;

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  logic [fdsp_pkg::TMR_W-1:0] tmr_r;
  logic [fdsp_pkg::TMR_W-1:0] tmr_nxt;
  logic                       por_sleep_r;
  logic                       por_done_r;
  logic                       reload_r;
  logic [7:0]                 nv_r;
  logic [7:0]                 v_r;

  localparam logic [fdsp_pkg::TMR_W-1:0] PU_END = fdsp_pkg::TMR_W'(POWER_UP_CYCLES - 1);
  localparam logic [fdsp_pkg::TMR_W-1:0] EN_END = fdsp_pkg::TMR_W'(SLEEP_ENTRY_CYCLES - 1);
  localparam logic [fdsp_pkg::TMR_W-1:0] WP_END = fdsp_pkg::TMR_W'(WAKE_PULSE_CYCLES - 1);
  localparam logic [fdsp_pkg::TMR_W-1:0] EX_END = fdsp_pkg::TMR_W'(WAKE_EXIT_CYCLES - 1);

  wire sleep_bit = nv_r[fdsp_pkg::SLEEP_AFTER_PON_BIT];
  wire por_end   = (state_r == fdsp_pkg::ST_POR) & pwr_ok & ~hw_rst & (tmr_r == PU_END);
  // Reset while asleep wakes when the bit is clear or sleep came from power-on
  wire rst_wake  = hw_rst & ((~sleep_bit) | por_sleep_r);

  always_comb begin
    state_nxt = state_r;
    tmr_nxt   = tmr_r + fdsp_pkg::TMR_W'(1);
    case (state_r)
      fdsp_pkg::ST_POR: begin
        if (!pwr_ok || hw_rst) begin
          tmr_nxt = '0;
        end else if (tmr_r == PU_END) begin
          tmr_nxt   = '0;
          // A reset that undoes power-on sleep must land in standby, not sleep again
          state_nxt = (sleep_bit & ~por_sleep_r) ? fdsp_pkg::ST_ENTRY : fdsp_pkg::ST_ACT;
        end
      end
      fdsp_pkg::ST_ENTRY: begin
        if (tmr_r == EN_END) begin
          tmr_nxt   = '0;
          state_nxt = fdsp_pkg::ST_SLEEP;
        end
      end
      fdsp_pkg::ST_SLEEP: begin
        // Only chip select and the reset pin are watched here
        if (hw_rst) begin
          tmr_nxt   = '0;
          state_nxt = rst_wake ? fdsp_pkg::ST_POR : fdsp_pkg::ST_SLEEP;
        end else if (cs_n_s) begin
          tmr_nxt = '0;
        end else if (tmr_r == WP_END) begin
          tmr_nxt   = '0;
          state_nxt = fdsp_pkg::ST_EXIT;
        end
      end
      fdsp_pkg::ST_EXIT: begin
        if (tmr_r == EX_END) begin
          tmr_nxt   = '0;
          state_nxt = fdsp_pkg::ST_ACT;
        end
      end
      fdsp_pkg::ST_ACT: begin
        tmr_nxt = '0;
        if (hw_rst) begin
          state_nxt = fdsp_pkg::ST_POR;
        end else if (enter_cmd) begin
          state_nxt = fdsp_pkg::ST_ENTRY;
        end
      end
      default: begin
        tmr_nxt   = '0;
        state_nxt = fdsp_pkg::ST_POR;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_r <= fdsp_pkg::ST_POR;
      tmr_r   <= '0;
    end else begin
      state_r <= state_nxt;
      tmr_r   <= tmr_nxt;
    end
  end

  // Power-on sleep is remembered so a later reset can undo it
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      por_sleep_r <= 1'b0;
      por_done_r  <= 1'b0;
    end else begin
      if (por_end) begin
        por_sleep_r <= sleep_bit & ~por_done_r;
        por_done_r  <= 1'b1;
      end else if (state_r == fdsp_pkg::ST_ACT) begin
        por_sleep_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register layers
  // ----------------------------------------------------------------
  // Non-volatile image is taken at power-up; volatile copy is reloaded
  // at every reset completion, never on sleep exit.
  wire load_v = por_end | sw_reset_in;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      nv_r     <= nv_image_in;
      v_r      <= fdsp_pkg::CONFIG_FOUR_V_RESET;
      reload_r <= 1'b0;
    end else begin
      reload_r <= load_v;
      if (nv_wr_in) begin
        nv_r <= wr_data_in;
        v_r  <= wr_data_in;
      end else if (v_wr_in) begin
        v_r <= wr_data_in;
      end else if (load_v) begin
        v_r <= nv_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire leave_sleep = (state_r == fdsp_pkg::ST_SLEEP) & (state_nxt != fdsp_pkg::ST_SLEEP);

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      deep_sleep_out           <= 1'b0;
      device_ready_out         <= 1'b0;
      write_enable_latch_out   <= 1'b0;
      status_one_volatile_out  <= fdsp_pkg::STATUS_ONE_RESET;
      config_four_volatile_out <= fdsp_pkg::CONFIG_FOUR_V_RESET;
      config_four_nv_copy_out  <= fdsp_pkg::CONFIG_FOUR_V_RESET;
      diag_clear_out           <= 1'b0;
    end else begin
      deep_sleep_out   <= (state_nxt == fdsp_pkg::ST_SLEEP);
      device_ready_out <= (state_nxt == fdsp_pkg::ST_ACT);
      if (por_end || sw_reset_in) begin
        write_enable_latch_out <= 1'b0;
      end else if (wel_set_in && active) begin
        write_enable_latch_out <= 1'b1;
      end
      status_one_volatile_out <= {7'h00, busy_in} << fdsp_pkg::READY_BUSY_BIT;
      config_four_volatile_out <= v_r;
      config_four_nv_copy_out  <= nv_r;
      diag_clear_out           <= leave_sleep | reload_r;
    end
  end

endmodule

// File: dv/fdsp_power_ctrl_props.sv
// Port checker for the deep sleep power controller.
// Assumes it is bound onto every fdsp_power_ctrl instance.
`timescale 1ns/1ps
module fdsp_power_ctrl_props #(parameter int WAKE_EXIT_CYCLES = 10) (
  input wire logic       mclk_in,
  input wire logic       srst_in,
  input wire logic       busy_in,
  input wire logic       sw_reset_in,
  input wire logic       wel_set_in,
  input wire logic       nv_wr_in,
  input wire logic       v_wr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic       deep_sleep_out,
  input wire logic       device_ready_out,
  input wire logic       write_enable_latch_out,
  input wire logic [7:0] status_one_volatile_out,
  input wire logic [7:0] config_four_volatile_out,
  input wire logic [7:0] config_four_nv_copy_out
);
  logic [15:0] cnt_r;
  // Cycles since sleep ended; saturates so a long run never wraps
  always_ff @(posedge mclk_in) begin
    if (srst_in || deep_sleep_out) cnt_r <= 16'h0000;
    else if (cnt_r != 16'hFFFF) cnt_r <= cnt_r + 16'h0001;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  sequence s_both_layers;
    ##2 (config_four_nv_copy_out == $past(wr_data_in, 2) && config_four_volatile_out == $past(wr_data_in, 2));
  endsequence
  a_sleep_not_ready: assert property (deep_sleep_out |-> !device_ready_out)
    else $error("ready while asleep");
  a_exit_wait_count: assert property ($rose(device_ready_out) |-> cnt_r >= 16'(WAKE_EXIT_CYCLES - 1))
    else $error("ready too soon");
  a_busy_status_copy: assert property (!$past(srst_in) |-> status_one_volatile_out == {7'h00, $past(busy_in)})
    else $error("busy flag wrong");
  a_nv_write_both: assert property (nv_wr_in && device_ready_out && !sw_reset_in |-> s_both_layers)
    else $error("nv write lost");
  a_vol_write_keeps: assert property (v_wr_in && !nv_wr_in && device_ready_out && !sw_reset_in
      && !$past(nv_wr_in) && !$past(nv_wr_in, 2) |-> ##2 (config_four_volatile_out == $past(wr_data_in, 2)
      && config_four_nv_copy_out == $past(config_four_nv_copy_out, 2)))
    else $error("volatile write wrong");
  a_sw_reset_reload: assert property (sw_reset_in && device_ready_out
      |-> ##[1:3] (config_four_volatile_out == config_four_nv_copy_out && !write_enable_latch_out))
    else $error("no reload");
  a_asleep_no_wel: assert property (deep_sleep_out && $past(deep_sleep_out) && wel_set_in
      && !write_enable_latch_out |=> !write_enable_latch_out)
    else $error("latch set asleep");
  a_entry_after_gap: assert property ($rose(deep_sleep_out) |-> !$past(device_ready_out, 4))
    else $error("sleep without entry");
endmodule
bind fdsp_power_ctrl fdsp_power_ctrl_props #(.WAKE_EXIT_CYCLES(WAKE_EXIT_CYCLES)) u_props (
  .mclk_in(mclk_in), .srst_in(srst_in), .busy_in(busy_in), .sw_reset_in(sw_reset_in), .wel_set_in(wel_set_in),
  .nv_wr_in(nv_wr_in), .v_wr_in(v_wr_in), .wr_data_in(wr_data_in), .deep_sleep_out(deep_sleep_out),
  .device_ready_out(device_ready_out), .write_enable_latch_out(write_enable_latch_out),
  .status_one_volatile_out(status_one_volatile_out), .config_four_volatile_out(config_four_volatile_out),
  .config_four_nv_copy_out(config_four_nv_copy_out));

// File: dv/fdsp_host_model.sv
// Host side of the link: select, serial clock and data.
// Serial clock has a 48 ns period and runs only inside frames.
`timescale 1ns/1ps
module fdsp_host_model (
  output logic cs_n_out,
  output logic sclk_out,
  output logic si_out
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out   = 1'b0;
  end
  // Opcode MSB first; select held long enough for the flag to cross
  task automatic frame(input logic [7:0] op, input int nclk);
    // Step off the core clock edge so select never changes as it is sampled
    #7;
    cs_n_out = 1'b0;
    #48;
    for (int i = 0; i < nclk; i++) begin
      si_out = op[7 - (i % 8)];
      #24 sclk_out = 1'b1;
      #24 sclk_out = 1'b0;
    end
    si_out = ~si_out;
    #400 cs_n_out = 1'b1;
    #100;
  endtask
  task automatic wake(input int ns);
    #7;
    cs_n_out = 1'b0;
    #(ns) cs_n_out = 1'b1;
    #200;
  endtask
endmodule

// File: dv/fdsp_power_ctrl_tb.sv
// Self-checking bench for the deep sleep power controller.
// Assumes the host model on the link and the bound checker.
`timescale 1ns/1ps
module fdsp_power_ctrl_tb;
  localparam int PU = 20;
  localparam int SE = 4;
  localparam int WX = 10;
  localparam int K_NV = 0;
  localparam int K_V = 1;
  localparam int K_WEL = 2;
  localparam int K_SW = 3;
  localparam int K_HW = 4;
  logic       mclk_in = 1'b0, srst_in = 1'b1, hw_reset_n_in = 1'b1, supply_ok_in = 1'b0, busy_in = 1'b0;
  logic       sw_reset_in = 1'b0, wel_set_in = 1'b0, nv_wr_in = 1'b0, v_wr_in = 1'b0, diag_seen = 1'b0;
  logic [7:0] nv_image_in = 8'h00, wr_data_in = 8'h00, cfg, d;
  wire        cs_n, sclk, si, deep_sleep_out, device_ready_out, write_enable_latch_out, diag_clear_out;
  wire  [7:0] status_one_volatile_out, config_four_volatile_out, config_four_nv_copy_out;
  int         n_errors = 0, samples_checked = 0, c;
  always #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (diag_clear_out === 1'b1) diag_seen <= 1'b1;
  fdsp_host_model host (.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si));
  fdsp_power_ctrl #(.POWER_UP_CYCLES(PU), .SLEEP_ENTRY_CYCLES(SE), .WAKE_PULSE_CYCLES(2), .WAKE_EXIT_CYCLES(WX)) dut (
    .mclk_in(mclk_in), .srst_in(srst_in), .sclk_in(sclk), .cs_n_in(cs_n), .si_in(si), .hw_reset_n_in(hw_reset_n_in),
    .supply_ok_in(supply_ok_in), .busy_in(busy_in), .sw_reset_in(sw_reset_in), .wel_set_in(wel_set_in),
    .nv_image_in(nv_image_in), .nv_wr_in(nv_wr_in), .v_wr_in(v_wr_in), .wr_data_in(wr_data_in),
    .deep_sleep_out(deep_sleep_out), .device_ready_out(device_ready_out),
    .write_enable_latch_out(write_enable_latch_out), .status_one_volatile_out(status_one_volatile_out),
    .config_four_volatile_out(config_four_volatile_out), .config_four_nv_copy_out(config_four_nv_copy_out),
    .diag_clear_out(diag_clear_out));
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) n_errors++;
    if (got !== exp) $display("Error at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) n_errors++;
    if (got !== exp) $display("Error at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // Bounded wait until the device is either ready or asleep
  task automatic settle;
    c = 0;
    while (device_ready_out !== 1'b1 && deep_sleep_out !== 1'b1 && c < 300) begin
      cyc(1);
      c++;
    end
    cyc(2);
  endtask
  // Drives one bench control to v; the reset pin is active low and idles high
  task automatic drive(input int k, input logic v);
    case (k)
      K_NV: nv_wr_in <= v;
      K_V: v_wr_in <= v;
      K_WEL: wel_set_in <= v;
      K_SW: sw_reset_in <= v;
      default: hw_reset_n_in <= ~v;
    endcase
  endtask
  task automatic pulse(input int k);
    drive(k, 1'b1);
    cyc(1);
    drive(k, 1'b0);
    cyc(3);
  endtask
  task automatic power_up(input logic [7:0] img, input logic glitch);
    srst_in <= 1'b1;
    nv_image_in <= img;
    cyc(6);
    srst_in <= 1'b0;
    supply_ok_in <= 1'b1;
    if (glitch) cyc(10);
    if (glitch) pulse(K_HW);
    settle;
    chk_bit(c >= PU, 1'b1);
    chk_bit(write_enable_latch_out, 1'b0);
    chk_byte(config_four_volatile_out, img);
    chk_bit(deep_sleep_out, img[2]);
    $display("Power-up test done");
  endtask
  task automatic wake_up(input logic by_pin);
    diag_seen <= 1'b0;
    pulse(K_WEL);
    if (by_pin) pulse(K_HW);
    else host.wake(500);
    chk_bit(deep_sleep_out, 1'b0);
    chk_bit(device_ready_out, 1'b0);
    settle;
    chk_bit(device_ready_out, 1'b1);
    chk_bit(diag_seen, 1'b1);
  endtask
  function automatic logic sleeps(input logic [7:0] op, input int n, input logic b);
    return op == fdsp_pkg::ENTER_DEEP_SLEEP_CMD && n == 8 && !b;
  endfunction
  task automatic try_sleep(input logic [7:0] op, input int n, input logic b, input logic by_pin);
    busy_in <= b;
    cyc(1);
    host.frame(op, n);
    cyc(SE + 4);
    chk_byte(status_one_volatile_out, {7'h00, b});
    busy_in <= 1'b0;
    chk_bit(deep_sleep_out, sleeps(op, n, b));
    if (deep_sleep_out === 1'b1) wake_up(by_pin);
    chk_byte(config_four_volatile_out, cfg);
    $display("Sleep test done");
  endtask
  initial begin
    void'($urandom(32'h429D));
    cfg = 8'($urandom()) & 8'hFB;
    power_up(cfg, 1'b0);
    power_up(cfg, 1'b1);
    repeat (4) begin
      cfg = 8'($urandom()) & 8'hFB;
      d = 8'($urandom());
      wr_data_in <= cfg;
      pulse(K_NV);
      chk_byte(config_four_nv_copy_out, cfg);
      chk_byte(config_four_volatile_out, cfg);
      wr_data_in <= d;
      pulse(K_V);
      chk_byte(config_four_nv_copy_out, cfg);
      chk_byte(config_four_volatile_out, d);
    end
    pulse(K_WEL);
    chk_bit(write_enable_latch_out, 1'b1);
    pulse(K_SW);
    chk_bit(write_enable_latch_out, 1'b0);
    chk_byte(config_four_volatile_out, cfg);
    $display("Write test done");
    try_sleep(fdsp_pkg::ENTER_DEEP_SLEEP_CMD, 9, 1'b0, 1'b0);
    try_sleep(fdsp_pkg::ENTER_DEEP_SLEEP_CMD, 8, 1'b1, 1'b0);
    repeat (3) try_sleep(8'($urandom()), 8, 1'b0, 1'b0);
    try_sleep(fdsp_pkg::ENTER_DEEP_SLEEP_CMD, 8, 1'b0, 1'b0);
    try_sleep(fdsp_pkg::ENTER_DEEP_SLEEP_CMD, 8, 1'b0, 1'b1);
    power_up(cfg | 8'h04, 1'b0);
    wake_up(1'b0);
    power_up(cfg | 8'h04, 1'b0);
    wake_up(1'b1);
    end_of_test;
  end
  initial begin
    #1000000;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test;
  end
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
endmodule
